// ### rtl/pfcms_pkg.sv
// Shared constants and types of the PFC mode supervisor
`default_nettype none
package pfcms_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 250_000_000;
	localparam int unsigned SWITCH_FREQ_HZ = 22_200;
	localparam int unsigned SWITCH_PERIOD_CYC = CLK_FREQ_HZ / SWITCH_FREQ_HZ;
	localparam int PERIOD_W = 16;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
	localparam logic [3:0] IRQ_MASK_OFS = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RESET = 1'h1;
	// Interrupt status and mask layout
	localparam int IRQ_W = 5;
	localparam int IRQ_SLEEP = 0;
	localparam int IRQ_STANDBY = 1;
	localparam int IRQ_OVP = 2;
	localparam int IRQ_PEAK = 3;
	localparam int IRQ_NORMAL = 4;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
	// Status layout: mode in [4:0]
	localparam int STAT_OVP_BIT = 5;
	localparam int STAT_LINE_BIT = 6;
	localparam int STAT_SUPPLY_BIT = 7;
	localparam int STAT_GATE_BIT = 8;
	// ----------------------------------------------------------------
	// Comparator synchroniser lanes
	// ----------------------------------------------------------------
	localparam int SYNC_W = 11;
	localparam int S_TURN_ON = 0;
	localparam int S_DROPOUT = 1;
	localparam int S_SLEEP = 2;
	localparam int S_LINE_EN = 3;
	localparam int S_LINE_FLT = 4;
	localparam int S_OPEN_LOOP = 5;
	localparam int S_OVP = 6;
	localparam int S_OVP_REL = 7;
	localparam int S_PEAK = 8;
	localparam int S_COMP = 9;
	localparam int S_PWM_END = 10;
	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		MODE_SLEEP = 5'h01,
		MODE_SLEEP_DIS = 5'h02,
		MODE_STANDBY = 5'h04,
		MODE_SOFT = 5'h08,
		MODE_NORMAL = 5'h10
	} pfcms_mode_t;
endpackage
`default_nettype wire

// ### rtl/pfcms_sync.sv
// Two-flop level synchroniser, one lane per bit
`default_nettype none
module pfcms_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	// Levels
	input wire logic [WIDTH-1:0] levelIn,
	output logic [WIDTH-1:0] levelOut
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			logic stage1_r;
			logic stage2_r;
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					stage1_r <= 1'h0;
					stage2_r <= 1'h0;
				end else if (clkEn) begin
					stage1_r <= levelIn[i];
					stage2_r <= stage1_r;
				end
			end
			assign levelOut[i] = stage2_r;
		end
	endgenerate
endmodule
`default_nettype wire

// ### rtl/pfcms_supervisor.sv
// PFC mode supervisor: mode sequencing, gate control, register slave
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`default_nettype none
module pfcms_supervisor
	import pfcms_pkg::*;
#(
	parameter int unsigned SWITCH_PERIOD = SWITCH_PERIOD_CYC
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	// Comparator levels
	input wire logic supplyAboveTurnOn,
	input wire logic supplyAboveDropout,
	input wire logic sleepRequest,
	input wire logic lineAboveEnable,
	input wire logic lineAboveFault,
	input wire logic openLoopFault,
	input wire logic outputOvervoltageFault,
	input wire logic overvoltageAboveRelease,
	input wire logic peakCurrentFault,
	input wire logic compAboveStart,
	input wire logic pwmEnd,
	// Power stage controls and interrupt
	output logic gateOut,
	output logic compDischarge,
	output logic biasEnable,
	output logic irq,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam logic [PERIOD_W-1:0] PER_LAST = PERIOD_W'(SWITCH_PERIOD - 1);
	localparam logic [PERIOD_W-1:0] PER_CUT = PERIOD_W'(SWITCH_PERIOD - 2);

	// ----------------------------------------------------------------
	// Comparator synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] rawLevels;
	logic [SYNC_W-1:0] lvl;
	assign rawLevels = {pwmEnd, compAboveStart, peakCurrentFault,
		overvoltageAboveRelease, outputOvervoltageFault, openLoopFault,
		lineAboveFault, lineAboveEnable, sleepRequest,
		supplyAboveDropout, supplyAboveTurnOn};
	pfcms_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.levelIn(rawLevels),
		.levelOut(lvl)
	);

	// ----------------------------------------------------------------
	// Mode state machine
	// ----------------------------------------------------------------
	pfcms_mode_t mode_r, mode_nxt;
	logic supplyOk_r, supplyOk_nxt;
	logic lineOk_r, lineOk_nxt;
	logic ctrlEn_r;
	logic standbyCond;
	always_comb begin
		supplyOk_nxt = supplyOk_r;
		if (lvl[S_TURN_ON])
			supplyOk_nxt = 1'h1;
		else if (!lvl[S_DROPOUT])
			supplyOk_nxt = 1'h0;
		lineOk_nxt = lineOk_r;
		if (lvl[S_LINE_EN])
			lineOk_nxt = 1'h1;
		else if (!lvl[S_LINE_FLT])
			lineOk_nxt = 1'h0;
		standbyCond = !lineOk_r || lvl[S_OPEN_LOOP] || !ctrlEn_r;
		mode_nxt = mode_r;
		if (!supplyOk_r) begin
			mode_nxt = MODE_SLEEP;
		end else if (lvl[S_SLEEP]) begin
			if (mode_r == MODE_SLEEP)
				mode_nxt = MODE_SLEEP;
			else if (lvl[S_COMP])
				mode_nxt = MODE_SLEEP_DIS;
			else
				mode_nxt = MODE_SLEEP;
		end else if (standbyCond) begin
			mode_nxt = MODE_STANDBY;
		end else begin
			unique case (mode_r)
				MODE_SLEEP, MODE_SLEEP_DIS: mode_nxt = MODE_STANDBY;
				MODE_STANDBY: begin
					if (!lvl[S_COMP])
						mode_nxt = MODE_SOFT;
				end
				MODE_SOFT: begin
					if (lvl[S_COMP])
						mode_nxt = MODE_NORMAL;
				end
				MODE_NORMAL: mode_nxt = MODE_NORMAL;
				default: mode_nxt = MODE_SLEEP;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= MODE_SLEEP;
			supplyOk_r <= 1'h0;
			lineOk_r <= 1'h0;
		end else if (clkEn) begin
			mode_r <= mode_nxt;
			supplyOk_r <= supplyOk_nxt;
			lineOk_r <= lineOk_nxt;
		end
	end
	// Discharge in stand-by and both sleep states while above start
	assign compDischarge = (mode_r != MODE_SOFT) && (mode_r != MODE_NORMAL)
		&& lvl[S_COMP];
	assign biasEnable = (mode_r != MODE_SLEEP);

	// ----------------------------------------------------------------
	// Oscillator and gate
	// ----------------------------------------------------------------
	logic [PERIOD_W-1:0] periodCnt_r, periodCnt_nxt;
	logic gate_r, gate_nxt;
	logic ovpLatch_r, ovpLatch_nxt;
	logic switchOn;
	always_comb begin
		periodCnt_nxt = (periodCnt_r == PER_LAST) ? '0 :
			periodCnt_r + PERIOD_W'(1);
		ovpLatch_nxt = ovpLatch_r;
		if (lvl[S_OVP])
			ovpLatch_nxt = 1'h1;
		else if (!lvl[S_OVP_REL])
			ovpLatch_nxt = 1'h0;
		switchOn = ((mode_nxt == MODE_SOFT) || (mode_nxt == MODE_NORMAL))
			&& lvl[S_COMP] && !ovpLatch_r;
		if (!switchOn)
			gate_nxt = 1'h0;
		else if (periodCnt_r == PER_LAST)
			gate_nxt = 1'h1;
		else if (periodCnt_r == PER_CUT || lvl[S_PWM_END])
			gate_nxt = 1'h0;
		else
			gate_nxt = gate_r;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			periodCnt_r <= '0;
			gate_r <= 1'h0;
			ovpLatch_r <= 1'h0;
		end else if (clkEn) begin
			periodCnt_r <= periodCnt_nxt;
			gate_r <= gate_nxt;
			ovpLatch_r <= ovpLatch_nxt;
		end
	end
	// Fault paths bypass the synchronisers
	assign gateOut = gate_r && compAboveStart && !peakCurrentFault
		&& !outputOvervoltageFault && !ovpLatch_r;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irqStat_r, irqStat_nxt;
	logic [IRQ_W-1:0] irqMask_r, irqMask_nxt;
	logic [IRQ_W-1:0] irqEvent;
	logic [IRQ_W-1:0] irqClr;
	logic peakSeen_r;
	logic wrFire;
	logic [ADDR_W-1:0] wrAddr_r;
	logic [DATA_W-1:0] wrData_r;
	logic [3:0] wrStrb_r;
	logic ctrlEn_nxt;
	always_comb begin
		irqEvent = '0;
		irqEvent[IRQ_SLEEP] = mode_nxt == MODE_SLEEP && mode_r != MODE_SLEEP;
		irqEvent[IRQ_STANDBY] = mode_nxt == MODE_STANDBY
			&& mode_r != MODE_STANDBY;
		irqEvent[IRQ_OVP] = ovpLatch_nxt && !ovpLatch_r;
		irqEvent[IRQ_PEAK] = lvl[S_PEAK] && !peakSeen_r;
		irqEvent[IRQ_NORMAL] = mode_nxt == MODE_NORMAL
			&& mode_r != MODE_NORMAL;
		irqClr = '0;
		if (wrFire && wrAddr_r == IRQ_STAT_OFS && wrStrb_r[0])
			irqClr = wrData_r[IRQ_W-1:0];
		irqStat_nxt = (irqStat_r & ~irqClr) | irqEvent;
		irqMask_nxt = irqMask_r;
		if (wrFire && wrAddr_r == IRQ_MASK_OFS && wrStrb_r[0])
			irqMask_nxt = wrData_r[IRQ_W-1:0];
		ctrlEn_nxt = ctrlEn_r;
		if (wrFire && wrAddr_r == CTRL_OFS && wrStrb_r[0])
			ctrlEn_nxt = wrData_r[CTRL_EN_BIT];
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irqStat_r <= '0;
			irqMask_r <= IRQ_MASK_RESET;
			peakSeen_r <= 1'h0;
			ctrlEn_r <= CTRL_EN_RESET;
		end else if (clkEn) begin
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			peakSeen_r <= lvl[S_PEAK];
			ctrlEn_r <= ctrlEn_nxt;
		end
	end
	assign irq = |(irqStat_r & irqMask_r);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic awHave_r, awHave_nxt;
	logic wHave_r, wHave_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic [ADDR_W-1:0] wrAddr_nxt;
	logic [DATA_W-1:0] wrData_nxt;
	logic [3:0] wrStrb_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic [DATA_W-1:0] statusWord;
	assign s_axi_awready = !awHave_r && !bvalid_r;
	assign s_axi_wready = !wHave_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wrFire = awHave_r && wHave_r && !bvalid_r;
	always_comb begin
		statusWord = '0;
		statusWord[4:0] = mode_r;
		statusWord[STAT_OVP_BIT] = ovpLatch_r;
		statusWord[STAT_LINE_BIT] = lineOk_r;
		statusWord[STAT_SUPPLY_BIT] = supplyOk_r;
		statusWord[STAT_GATE_BIT] = gate_r;
		awHave_nxt = awHave_r;
		wHave_nxt = wHave_r;
		wrAddr_nxt = wrAddr_r;
		wrData_nxt = wrData_r;
		wrStrb_nxt = wrStrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			awHave_nxt = 1'h1;
			wrAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHave_nxt = 1'h1;
			wrData_nxt = s_axi_wdata;
			wrStrb_nxt = s_axi_wstrb;
		end
		if (wrFire) begin
			awHave_nxt = 1'h0;
			wHave_nxt = 1'h0;
			bvalid_nxt = 1'h1;
			bresp_nxt = (wrAddr_r == CTRL_OFS || wrAddr_r == STATUS_OFS
				|| wrAddr_r == IRQ_STAT_OFS || wrAddr_r == IRQ_MASK_OFS)
				? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'h0;
		end
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'h1;
			rresp_nxt = RESP_OKAY;
			unique case (s_axi_araddr)
				CTRL_OFS: rdata_nxt = {{(DATA_W-1){1'h0}}, ctrlEn_r};
				STATUS_OFS: rdata_nxt = statusWord;
				IRQ_STAT_OFS: rdata_nxt = {{(DATA_W-IRQ_W){1'h0}}, irqStat_r};
				IRQ_MASK_OFS: rdata_nxt = {{(DATA_W-IRQ_W){1'h0}}, irqMask_r};
				default: begin
					rdata_nxt = '0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'h0;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			awHave_r <= 1'h0;
			wHave_r <= 1'h0;
			wrAddr_r <= '0;
			wrData_r <= '0;
			wrStrb_r <= '0;
			bvalid_r <= 1'h0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'h0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end else if (clkEn) begin
			awHave_r <= awHave_nxt;
			wHave_r <= wHave_nxt;
			wrAddr_r <= wrAddr_nxt;
			wrData_r <= wrData_nxt;
			wrStrb_r <= wrStrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_gate_comp_low: assert property (!compAboveStart |-> !gateOut)
		else $error("gate high with compensation below start");
	a_standby_discharge: assert property (
		(mode_r == MODE_STANDBY && lvl[S_COMP]) |-> compDischarge)
		else $error("no discharge in stand-by");
	a_prebias_block: assert property (
		(clkEn && mode_r == MODE_STANDBY && lvl[S_COMP]) |=>
		mode_r != MODE_SOFT)
		else $error("soft-start despite pre-bias");
	a_peak_gate_off: assert property (peakCurrentFault |-> !gateOut)
		else $error("gate high during peak current");
	a_line_enable: assert property (
		(clkEn && mode_r == MODE_STANDBY && !lineOk_r && !lvl[S_LINE_EN])
		|=> mode_r != MODE_SOFT)
		else $error("left stand-by without line enable");
	a_line_hyst: assert property (
		(clkEn && lineOk_r && lvl[S_LINE_FLT]) |=> lineOk_r)
		else $error("line fault without line below fault level");
	a_open_loop: assert property (
		(clkEn && lvl[S_OPEN_LOOP]) |=>
		(mode_r != MODE_SOFT && mode_r != MODE_NORMAL))
		else $error("running with open loop");
	a_sleep_req: assert property (
		(clkEn && supplyOk_r && lvl[S_SLEEP] && mode_r == MODE_NORMAL)
		|=> (mode_r == MODE_SLEEP || mode_r == MODE_SLEEP_DIS))
		else $error("sleep request ignored");
	a_uvlo_entry: assert property (
		(clkEn && !supplyOk_r) |=> mode_r == MODE_SLEEP)
		else $error("no sleep on low supply");
	a_sleep_unbias: assert property (
		mode_r == MODE_SLEEP |-> (!biasEnable && !gateOut))
		else $error("biased or gate on in sleep");
	a_sleep_discharge: assert property (
		(clkEn && mode_r == MODE_SLEEP_DIS && supplyOk_r && lvl[S_SLEEP]
		&& lvl[S_COMP]) |=> mode_r == MODE_SLEEP_DIS)
		else $error("sleep before discharge done");
	a_standby_bias: assert property (
		mode_r == MODE_STANDBY |-> (biasEnable && !gateOut))
		else $error("stand-by bias or gate wrong");
	a_ovp_hold: assert property (
		(clkEn && ovpLatch_r && lvl[S_OVP_REL]) |=> (ovpLatch_r && !gateOut))
		else $error("overvoltage released early");
	a_period_start: assert property (
		$rose(gate_r) |-> periodCnt_r == '0)
		else $error("gate pulse off the period start");
endmodule
`default_nettype wire

// ### verification/pfcms_comparators.sv
// Behavioural comparator bank and compensation node at the supervisor pins
`default_nettype none
module pfcms_comparators (
	// Clock
	input wire logic clk_sys,
	// Sensed levels, arbitrary scale
	input wire logic [7:0] supply,
	input wire logic [7:0] line,
	input wire logic [7:0] feedback,
	input wire logic [7:0] ovSense,
	input wire logic [7:0] current,
	// Compensation node controls
	input wire logic compCharge,
	input wire logic compPreset,
	// From the supervisor
	input wire logic gateOut,
	input wire logic compDischarge,
	input wire logic biasEnable,
	// Comparator levels
	output logic supplyAboveTurnOn,
	output logic supplyAboveDropout,
	output logic sleepRequest,
	output logic lineAboveEnable,
	output logic lineAboveFault,
	output logic openLoopFault,
	output logic outputOvervoltageFault,
	output logic overvoltageAboveRelease,
	output logic peakCurrentFault,
	output logic compAboveStart,
	output logic pwmEnd
);
	timeunit 1ns;
	timeprecision 1ps;
	int comp = 0;
	int onTime = 0;
	// Thresholds on the arbitrary level scale
	assign supplyAboveTurnOn = supply > 100;
	assign supplyAboveDropout = supply > 80;
	assign sleepRequest = ovSense < 10;
	assign lineAboveEnable = line > 100;
	assign lineAboveFault = line > 80;
	assign openLoopFault = feedback < 50;
	assign outputOvervoltageFault = ovSense > 106;
	assign overvoltageAboveRelease = ovSense > 103;
	assign peakCurrentFault = current > 100;
	assign compAboveStart = comp > 40;
	assign pwmEnd = onTime >= 6;
	// Error amplifier only charges while biased
	always @(posedge clk_sys) begin
		if (compPreset)
			comp <= 80;
		else if (compDischarge === 1'b1)
			comp <= (comp > 4) ? comp - 4 : 0;
		else if (compCharge && biasEnable === 1'b1 && comp < 80)
			comp <= comp + 2;
		onTime <= (gateOut === 1'b1) ? onTime + 1 : 0;
	end
endmodule
`default_nettype wire

// ### verification/pfcms_supervisor_test.sv
// Self-checking bench of the PFC mode supervisor
`default_nettype none
module pfcms_supervisor_test
	import pfcms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 20;
	logic clk_sys, reset_n, clkEn, compCharge, compPreset;
	logic [7:0] supply, line, feedback, ovSense, current;
	logic supplyAboveTurnOn, supplyAboveDropout, sleepRequest;
	logic lineAboveEnable, lineAboveFault, openLoopFault;
	logic outputOvervoltageFault, overvoltageAboveRelease;
	logic peakCurrentFault, compAboveStart, pwmEnd;
	logic gateOut, compDischarge, biasEnable, irq;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic gatePrev = 0, mSup = 0, mLine = 0, mOv = 0, mEn = 1;
	int num_errors = 0, compares = 0, seed = 21010;
	int cyc = 0, rises = 0, lastRise = 0, period = 0;
	int lo[4] = '{81, 0, 81, 101};
	int hi[4] = '{100, 80, 100, 200};

	pfcms_supervisor #(.SWITCH_PERIOD(PER)) i_pfcms_supervisor (
		.clk_sys, .reset_n, .clkEn, .supplyAboveTurnOn,
		.supplyAboveDropout, .sleepRequest, .lineAboveEnable,
		.lineAboveFault, .openLoopFault, .outputOvervoltageFault,
		.overvoltageAboveRelease, .peakCurrentFault, .compAboveStart,
		.pwmEnd, .gateOut, .compDischarge, .biasEnable, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	pfcms_comparators i_pfcms_comparators (
		.clk_sys, .supply, .line, .feedback, .ovSense, .current,
		.compCharge, .compPreset, .gateOut, .compDischarge, .biasEnable,
		.supplyAboveTurnOn, .supplyAboveDropout, .sleepRequest,
		.lineAboveEnable, .lineAboveFault, .openLoopFault,
		.outputOvervoltageFault, .overvoltageAboveRelease,
		.peakCurrentFault, .compAboveStart, .pwmEnd
	);

	// ----------------------------------------------------------------
	// Clock and gate pulse monitor
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		cyc++;
		if (gateOut === 1'b1 && !gatePrev) begin
			rises++;
			period = cyc - lastRise;
			lastRise = cyc;
		end
		gatePrev = (gateOut === 1'b1);
	end

	// ----------------------------------------------------------------
	// Checking, bus and model tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("%0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic expire();
		check(32'h0, 32'h1);
		test_done();
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (ah) s_axi_awvalid <= 0;
			if (wh) s_axi_wvalid <= 0;
			if (bh === 1'b1) begin
				s_axi_bready <= 0;
				return;
			end
		end
		expire();
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ah, rh;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			if (ah) s_axi_arvalid <= 0;
			if (rh === 1'b1) begin
				s_axi_rready <= 0;
				return;
			end
		end
		expire();
	endtask
	function automatic logic [7:0] rnd(input int l, input int h);
		return 8'(l + $unsigned($random(seed)) % (h - l + 1));
	endfunction
	// Mode model: hysteresis flags, then priority of conditions
	function automatic logic [7:0] expect_status();
		pfcms_mode_t m;
		if (supply > 100) mSup = 1;
		else if (supply <= 80) mSup = 0;
		if (line > 100) mLine = 1;
		else if (line <= 80) mLine = 0;
		if (ovSense > 106) mOv = 1;
		else if (ovSense <= 103) mOv = 0;
		if (!mSup || ovSense < 10) m = MODE_SLEEP;
		else if (!mLine || feedback < 50 || !mEn) m = MODE_STANDBY;
		else if (compCharge) m = MODE_NORMAL;
		else m = MODE_SOFT;
		return {mSup, mLine, mOv, m};
	endfunction
	task automatic settle();
		logic [7:0] e;
		logic g;
		int r0;
		@(negedge clk_sys);
		e = expect_status();
		g = e[4:0] == MODE_NORMAL && !mOv && current <= 100;
		rd = 'x;
		for (int n = 0; n < 60 && rd[7:0] !== e; n++)
			axi_rd(STATUS_OFS, rd, rs);
		check(32'(rd[7:0]), 32'(e));
		check(32'(biasEnable), 32'(e[4:0] != MODE_SLEEP));
		r0 = rises;
		repeat (2 * PER) @(negedge clk_sys);
		check(32'(rises != r0), 32'(g));
	endtask
	task automatic fault_at_gate(input logic ov);
		int r0;
		r0 = rises;
		for (int n = 0; n < 100 && rises == r0; n++) @(negedge clk_sys);
		check(32'(rises != r0), 1);
		@(posedge clk_sys);
		if (ov)
			ovSense <= 8'd120;
		else
			current <= 8'd150;
		#1 check(32'(gateOut), 0);
	endtask
	task automatic see_discharge();
		for (int n = 0; n < 50 && compDischarge !== 1'b1; n++)
			@(negedge clk_sys);
		check(32'(compDischarge), 1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 0;
		clkEn = 1;
		{compCharge, compPreset, supply, line, feedback, current} = '0;
		ovSense = 8'd100;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1;
		axi_rd(CTRL_OFS, rd, rs);
		check(rd, 32'(CTRL_EN_RESET));
		axi_rd(IRQ_MASK_OFS, rd, rs);
		check(rd, 32'(IRQ_MASK_RESET));
		axi_rd(4'h2, rd, rs);
		check(32'(rs), 32'(RESP_SLVERR));
		axi_wr(STATUS_OFS, 32'h1f, rs);
		check(32'(rs), 32'(RESP_OKAY));
		settle();
		$display("reset test done");
		@(posedge clk_sys);
		supply <= rnd(101, 200);
		line <= rnd(81, 100);
		feedback <= rnd(50, 200);
		ovSense <= rnd(20, 100);
		current <= rnd(0, 100);
		settle();
		@(posedge clk_sys) compPreset <= 1;
		@(posedge clk_sys) compPreset <= 0;
		repeat (5) @(negedge clk_sys);
		check(32'(compDischarge), 1);
		check(32'(gateOut), 0);
		@(posedge clk_sys);
		line <= rnd(101, 200);
		compCharge <= 1;
		settle();
		check(period, PER);
		$display("start-up test done");
		fault_at_gate(0);
		settle();
		@(posedge clk_sys) current <= rnd(0, 100);
		settle();
		fault_at_gate(1);
		settle();
		@(posedge clk_sys) ovSense <= 8'd105;
		settle();
		@(posedge clk_sys) ovSense <= rnd(20, 103);
		settle();
		$display("gate fault test done");
		@(posedge clk_sys) line <= rnd(0, 80);
		see_discharge();
		settle();
		@(posedge clk_sys) line <= rnd(81, 100);
		settle();
		@(posedge clk_sys) line <= rnd(101, 200);
		settle();
		@(posedge clk_sys) feedback <= rnd(0, 49);
		see_discharge();
		settle();
		@(posedge clk_sys) feedback <= 8'd50;
		settle();
		$display("stand-by test done");
		@(posedge clk_sys) ovSense <= rnd(0, 9);
		see_discharge();
		check(32'(biasEnable), 1);
		settle();
		@(posedge clk_sys);
		ovSense <= 8'd90;
		line <= 8'd30;
		settle();
		@(posedge clk_sys) line <= 8'd150;
		settle();
		@(posedge clk_sys) ovSense <= 8'd5;
		settle();
		@(posedge clk_sys) ovSense <= 8'd90;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) supply <= rnd(lo[i], hi[i]);
			settle();
		end
		$display("sleep and supply test done");
		axi_wr(IRQ_MASK_OFS, 32'h2, rs);
		axi_wr(IRQ_STAT_OFS, 32'h1f, rs);
		check(32'(irq), 0);
		axi_wr(CTRL_OFS, 32'h0, rs);
		mEn = 0;
		settle();
		check(32'(irq), 1);
		axi_rd(IRQ_STAT_OFS, rd, rs);
		check(32'(rd[IRQ_STANDBY]), 1);
		axi_wr(IRQ_STAT_OFS, 32'h2, rs);
		check(32'(irq), 0);
		axi_wr(CTRL_OFS, 32'h1, rs);
		mEn = 1;
		settle();
		axi_rd(IRQ_STAT_OFS, rd, rs);
		check(rd, 32'(1 << IRQ_NORMAL));
		$display("control and interrupt test done");
		@(posedge clk_sys);
		clkEn <= 0;
		supply <= 8'd0;
		repeat (10) @(negedge clk_sys);
		check(32'(biasEnable), 1);
		@(posedge clk_sys) clkEn <= 1;
		settle();
		$display("clock enable test done");
		test_done();
	end
endmodule
`default_nettype wire
